// ==== core/ssr_pkg.sv ====
/*
  ssr_pkg: constants, types and carriers for the speed select, ramp and
  dc brake block. Assumes one 250 MHz clock; frequencies are in 0.01 Hz.
*/
// What this block does
// - preset chosen only from high, middle, low and extra contact states
// - fifteen presets plus max and min limits give seventeen speeds
// - each preset may be 0 to 400 Hz, also while running
// - in three-speed use, several active inputs pick the lower-ranked one
// - speeds four to fifteen have no precedence; input code alone selects
// - preset changes while running apply at once, no stop needed
// - presets work in panel, external and network modes
// - increment select: 0 gives 0.1 s steps, 1 gives 0.01 s steps
// - accel time is zero to ramp reference frequency; slope scales from it
// - decel time is ramp reference frequency down to zero
// - second-function input swaps in second accel and decel times
// - second decel at the unused code means use second accel time
// - ramp time zero gives a 0.04 s ramp
// - s-curve A: time refers to base; above base uses the 4/9, 5/9 law
// - second-function input also swaps the other second settings
// - thermal current zero disables motor thermal protection
// - second thermal current used only with second-function on, unless unused
// - at stop, dc brake starts when output falls to brake start frequency
// - dc brake lasts the programmed brake time
// - brake voltage is a percentage, default 6, at most 30
// - default brake voltage becomes 4 when motor select turns constant-torque
package ssr_pkg;
  localparam longint CLK_PERIOD_NS = 4;
  localparam longint INC_COARSE_NS = 100_000_000;
  localparam longint INC_FINE_NS   = 10_000_000;
  localparam longint ZERO_RAMP_NS  = 40_000_000;
  localparam longint BRAKE_UNIT_NS = 100_000_000;
  localparam logic [31:0] INC_COARSE_CYC = 32'(INC_COARSE_NS / CLK_PERIOD_NS);
  localparam logic [31:0] INC_FINE_CYC   = 32'(INC_FINE_NS / CLK_PERIOD_NS);
  localparam logic [31:0] ZERO_RAMP_CYC  = 32'(ZERO_RAMP_NS / CLK_PERIOD_NS);
  localparam logic [31:0] BRAKE_UNIT_CYC = 32'(BRAKE_UNIT_NS / CLK_PERIOD_NS);

  localparam logic [15:0] FREQ_LIMIT     = 16'h9C40;
  localparam logic [15:0] FREQ_ZERO      = 16'h0000;
  localparam logic [15:0] FREQ_STEP      = 16'h0001;
  localparam logic [15:0] SETTING_UNUSED = 16'hFFFF;
  localparam logic [15:0] THERMAL_OFF    = 16'h0000;
  localparam logic [15:0] TIME_ZERO      = 16'h0000;
  localparam logic [7:0]  BOOST_UNUSED   = 8'hFF;
  localparam logic [7:0]  BRAKE_VOLT_DEFAULT = 8'h06;
  localparam logic [7:0]  BRAKE_VOLT_CT  = 8'h04;
  localparam logic [7:0]  BRAKE_VOLT_MAX = 8'h1E;
  localparam logic [7:0]  BRAKE_TIME_ZERO = 8'h00;
  localparam logic [7:0]  MOTOR_CT       = 8'h01;
  localparam logic [7:0]  LEVEL_OFF      = 8'h00;

  localparam logic [3:0] CODE_NONE   = 4'h0;
  localparam logic [3:0] CODE_HIGH   = 4'h1;
  localparam logic [3:0] CODE_MIDDLE = 4'h2;
  localparam logic [3:0] CODE_LOW    = 4'h3;
  localparam logic [3:0] CODE_COMBO_FIRST = 4'h4;
  localparam logic [3:0] CODE_COMBO_LAST  = 4'h7;

  localparam logic [3:0] SC_SQ_NUM  = 4'h4;
  localparam logic [3:0] SC_LIN_NUM = 4'h5;
  localparam logic [3:0] SC_DEN     = 4'h9;

  typedef enum logic [1:0] {SSR_MODE_PANEL, SSR_MODE_EXTERNAL, SSR_MODE_NETWORK} ssr_mode_t;
  typedef enum logic [1:0] {SSR_IDLE, SSR_RUN, SSR_STOPPING, SSR_BRAKE} ssr_phase_t;

  typedef struct packed {
    logic speed_sel_extra;
    logic speed_sel_high;
    logic speed_sel_middle;
    logic speed_sel_low;
  } ssr_speed_t;

  typedef logic [15:1][15:0] ssr_preset_tab_t;

  typedef struct packed {
    logic [15:0] accel_time;
    logic [15:0] decel_time;
    logic [15:0] second_accel_time;
    logic [15:0] second_decel_time;
    logic [15:0] ramp_reference_freq;
    logic [15:0] base_freq;
    logic        ramp_time_increment_sel;
    logic        scurve_a;
  } ssr_ramp_cfg_t;

  typedef struct packed {
    logic [15:0] motor_thermal_current;
    logic [15:0] second_motor_thermal_current;
    logic [7:0]  torque_boost;
    logic [7:0]  second_torque_boost;
  } ssr_second_cfg_t;

  typedef struct packed {
    logic [15:0] brake_start_freq;
    logic [7:0]  brake_duration;
  } ssr_brake_cfg_t;
endpackage

// ==== core/ssr_ramp_step.sv ====
/*
  ssr_ramp_step: rate accumulator that pulses once each time ref counts
  have accrued over span cycles. Assumes span of at least ref, so at most
  one pulse per cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module ssr_ramp_step
  import ssr_pkg::*;
(
  // clock and reset
  input  wire  logic        clk,
  input  wire  logic        rst,
  // rate
  input  wire  logic        enable,
  input  wire  logic [15:0] ref_count,
  input  wire  logic [47:0] span,
  // pulse
  output logic              step
);
  typedef struct packed {
    logic [47:0] acc;
    logic        step;
  } ssr_step_state_t;

  ssr_step_state_t s;
  ssr_step_state_t next_s;
  logic [47:0]     sum;

  always_comb
  begin
    next_s = s;
    sum    = s.acc + {32'h0000_0000, ref_count};
    next_s.step = 1'b0;
    if (!enable)
    begin
      // restart phase so a new ramp never inherits a half step
      next_s.acc = '0;
    end
    else if (sum >= span)
    begin
      next_s.acc  = sum - span;
      next_s.step = 1'b1;
    end
    else
    begin
      next_s.acc = sum;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign step = s.step;
endmodule // ssr_ramp_step
`default_nettype wire

// ==== core/ssr_top.sv ====
/*
  ssr_top: preset speed selection, accel/decel ramp, second-function
  switching, thermal enable and timed dc injection brake at stop.
  Assumes contact pins are asynchronous; network and setting inputs are
  on clk. Output frequency is in 0.01 Hz.
*/
`timescale 1ns/1ns
`default_nettype none
module ssr_top
  import ssr_pkg::*;
#(
  parameter logic [31:0] COARSE_CYC    = INC_COARSE_CYC,
  parameter logic [31:0] FINE_CYC      = INC_FINE_CYC,
  parameter logic [31:0] ZERO_CYC      = ZERO_RAMP_CYC,
  parameter logic [31:0] BRAKE_CYC     = BRAKE_UNIT_CYC
)
(
  // clock and reset
  input  wire  logic            clk,
  input  wire  logic            rst,
  // contact pins
  input  wire  ssr_speed_t      speed_pins,
  input  wire  logic            second_function_select,
  input  wire  logic            run_pin,
  // network side
  input  wire  ssr_mode_t       op_mode,
  input  wire  ssr_speed_t      net_speed,
  input  wire  logic            net_second,
  input  wire  logic            net_run,
  // settings
  input  wire  ssr_preset_tab_t presets,
  input  wire  logic [15:0]     freq_command,
  input  wire  logic [15:0]     max_freq,
  input  wire  logic [15:0]     min_freq,
  input  wire  ssr_ramp_cfg_t   ramp_cfg,
  input  wire  ssr_second_cfg_t second_cfg,
  input  wire  ssr_brake_cfg_t  brake_cfg,
  input  wire  logic [7:0]      brake_voltage_pct,
  input  wire  logic            brake_voltage_wr,
  input  wire  logic [7:0]      applied_motor_sel,
  // drive outputs
  output logic [15:0]           out_freq,
  output logic [3:0]            active_code,
  output logic                  brake_active,
  output logic [7:0]            brake_level,
  output logic [7:0]            brake_voltage_setting,
  // second-function outputs
  output logic                  second_active,
  output logic                  thermal_enable,
  output logic [15:0]           thermal_current,
  output logic [7:0]            torque_boost_out
);
  typedef struct packed {
    logic [5:0]  sync_a;
    logic [5:0]  sync_b;
    ssr_phase_t  phase;
    logic [15:0] freq;
    logic [31:0] brake_cnt;
    logic [7:0]  brake_volt;
    logic [7:0]  motor_prev;
    logic [3:0]  code;
    logic        brake_on;
    logic [7:0]  level;
    logic        second;
    logic        therm_en;
    logic [15:0] therm_cur;
    logic [7:0]  boost;
  } ssr_state_t;

  ssr_state_t s;
  ssr_state_t next_s;

  // contact pattern to speed number
  function automatic logic [3:0] speed_code(input ssr_speed_t v);
    logic [3:0] c;
    c = CODE_NONE;
    case ({v.speed_sel_extra, v.speed_sel_high, v.speed_sel_middle, v.speed_sel_low})
      4'h4: c = CODE_HIGH;
      4'h2: c = CODE_MIDDLE;
      4'h1: c = CODE_LOW;
      4'h3: c = 4'h4;
      4'h5: c = 4'h5;
      4'h6: c = 4'h6;
      4'h7: c = 4'h7;
      4'h8: c = 4'h8;
      4'h9: c = 4'h9;
      4'hA: c = 4'hA;
      4'hB: c = 4'hB;
      4'hC: c = 4'hC;
      4'hD: c = 4'hD;
      4'hE: c = 4'hE;
      4'hF: c = 4'hF;
      default: c = CODE_NONE;
    endcase
    return c;
  endfunction

  function automatic logic [15:0] preset_of(input logic [3:0] c);
    logic [15:0] v;
    v = SETTING_UNUSED;
    if (c != CODE_NONE)
      v = presets[c];
    return v;
  endfunction

  function automatic logic [15:0] fmax(input logic [15:0] a, input logic [15:0] b);
    return (a > b) ? a : b;
  endfunction

  function automatic logic [15:0] fmin(input logic [15:0] a, input logic [15:0] b);
    return (a < b) ? a : b;
  endfunction

  ssr_speed_t  pin_spd;
  ssr_speed_t  spd;
  logic        sec;
  logic        run;
  logic [3:0]  code_raw;
  logic [3:0]  code_eff;
  logic [15:0] preset_val;
  logic [15:0] sel_freq;
  logic [15:0] target;
  logic [15:0] acc_t;
  logic [15:0] dec_t;
  logic [15:0] t_set;
  logic [15:0] f_hi;
  logic [15:0] ref_lin;
  logic [15:0] ref_eff;
  logic [31:0] unit_cyc;
  logic [31:0] f_sq;
  logic [31:0] b_sq;
  logic [79:0] sc_num;
  logic [79:0] sc_den;
  logic [47:0] span_lin;
  logic [47:0] span;
  logic        going_up;
  logic        ramp_en;
  logic        step;
  logic [15:0] volt_clamp;

  always_comb
  begin
    pin_spd = ssr_speed_t'(s.sync_b[3:0]);
    // network mode takes its contacts from the master, others from pins
    if (op_mode == SSR_MODE_NETWORK)
    begin
      spd = net_speed;
      sec = net_second;
      run = net_run;
    end
    else
    begin
      spd = pin_spd;
      sec = s.sync_b[5];
      run = s.sync_b[4];
    end

    code_raw = speed_code(spd);
    code_eff = code_raw;
    // unset combination falls back to three-speed priority, lowest wins
    if (!spd.speed_sel_extra && code_raw >= CODE_COMBO_FIRST &&
        code_raw <= CODE_COMBO_LAST && preset_of(code_raw) == SETTING_UNUSED)
    begin
      if (spd.speed_sel_low)
        code_eff = CODE_LOW;
      else if (spd.speed_sel_middle)
        code_eff = CODE_MIDDLE;
      else
        code_eff = CODE_HIGH;
    end
    preset_val = preset_of(code_eff);

    // the plain command gets the same ceiling as the presets
    if (preset_val == SETTING_UNUSED)
      sel_freq = fmin(freq_command, FREQ_LIMIT);
    else
      sel_freq = fmin(preset_val, FREQ_LIMIT);
    sel_freq = fmax(fmin(sel_freq, max_freq), min_freq);
    target = (s.phase == SSR_RUN) ? sel_freq : FREQ_ZERO;

    acc_t = sec ? ramp_cfg.second_accel_time : ramp_cfg.accel_time;
    dec_t = ramp_cfg.decel_time;
    if (sec)
    begin
      if (ramp_cfg.second_decel_time == SETTING_UNUSED)
        dec_t = ramp_cfg.second_accel_time;
      else
        dec_t = ramp_cfg.second_decel_time;
    end
    going_up = s.freq < target;
    t_set    = going_up ? acc_t : dec_t;

    // cycles per setting unit come from the increment select
    unit_cyc = ramp_cfg.ramp_time_increment_sel ? FINE_CYC : COARSE_CYC;
    if (t_set == TIME_ZERO)
      span_lin = {16'h0000, ZERO_CYC};
    else
      span_lin = 48'(t_set) * 48'(unit_cyc);

    f_hi    = fmax(target, s.freq);
    ref_lin = ramp_cfg.scurve_a ? ramp_cfg.base_freq : ramp_cfg.ramp_reference_freq;
    f_sq    = 32'(f_hi) * 32'(f_hi);
    b_sq    = 32'(ramp_cfg.base_freq) * 32'(ramp_cfg.base_freq);
    sc_num  = 80'(span_lin) * (80'(SC_SQ_NUM) * 80'(f_sq) + 80'(SC_LIN_NUM) * 80'(b_sq));
    sc_den  = 80'(SC_DEN) * 80'(b_sq);
    span    = span_lin;
    ref_eff = ref_lin;
    // above base the whole run is stretched to the quadratic total time
    if (ramp_cfg.scurve_a && ramp_cfg.base_freq != FREQ_ZERO &&
        f_hi > ramp_cfg.base_freq)
    begin
      span    = 48'(sc_num / sc_den);
      ref_eff = f_hi;
    end
    // a zero reference would never step; treat it as one count
    if (ref_eff == FREQ_ZERO)
      ref_eff = FREQ_STEP;
    // faster than one count a cycle cannot be stepped; slow it to that
    if (span < 48'(ref_eff))
      span = 48'(ref_eff);

    ramp_en = (s.phase == SSR_RUN || s.phase == SSR_STOPPING) && (s.freq != target);
  end

  ssr_ramp_step u_step (
    .clk       (clk),
    .rst       (rst),
    .enable    (ramp_en),
    .ref_count (ref_eff),
    .span      (span),
    .step      (step)
  );

  always_comb
  begin
    next_s        = s;
    // two flops per pin; only sync_b is read by the logic
    next_s.sync_a = {second_function_select, run_pin, speed_pins};
    next_s.sync_b = s.sync_a;
    next_s.code   = code_eff;

    // direction rechecked here since the pulse lags the compare by a cycle
    if (step && ramp_en)
    begin
      if (s.freq < target)
        next_s.freq = s.freq + FREQ_STEP;
      else if (s.freq > target)
        next_s.freq = s.freq - FREQ_STEP;
    end

    unique case (s.phase)
      SSR_IDLE:
      begin
        if (run)
          next_s.phase = SSR_RUN;
      end
      SSR_RUN:
      begin
        if (!run)
          next_s.phase = SSR_STOPPING;
      end
      SSR_STOPPING:
      begin
        // already at or under the start point means the brake begins at once
        if (run)
          next_s.phase = SSR_RUN;
        else if (s.freq <= brake_cfg.brake_start_freq)
        begin
          next_s.freq = FREQ_ZERO;
          if (brake_cfg.brake_duration == BRAKE_TIME_ZERO)
            next_s.phase = SSR_IDLE;
          else
          begin
            next_s.phase     = SSR_BRAKE;
            next_s.brake_cnt = 32'(brake_cfg.brake_duration) * BRAKE_CYC - 32'h1;
          end
        end
      end
      SSR_BRAKE:
      begin
        // run during braking waits; the brake always completes its time
        next_s.freq = FREQ_ZERO;
        if (s.brake_cnt == 32'h0)
          next_s.phase = SSR_IDLE;
        else
          next_s.brake_cnt = s.brake_cnt - 32'h1;
      end
    endcase

    next_s.brake_on = (next_s.phase == SSR_BRAKE);

    next_s.motor_prev = applied_motor_sel;
    // clamp in sixteen bits so the shared helper serves here too
    volt_clamp = fmin({8'h00, brake_voltage_pct}, {8'h00, BRAKE_VOLT_MAX});
    if (brake_voltage_wr)
    begin
      // a write in the same cycle beats the constant-torque default change
      next_s.brake_volt = volt_clamp[7:0];
    end
    else if (applied_motor_sel != s.motor_prev && applied_motor_sel == MOTOR_CT &&
             s.brake_volt == BRAKE_VOLT_DEFAULT)
    begin
      next_s.brake_volt = BRAKE_VOLT_CT;
    end
    next_s.level = next_s.brake_on ? next_s.brake_volt : LEVEL_OFF;

    // every second setting follows the same effective select
    next_s.second = sec;
    if (sec && second_cfg.second_motor_thermal_current != SETTING_UNUSED)
      next_s.therm_cur = second_cfg.second_motor_thermal_current;
    else
      next_s.therm_cur = second_cfg.motor_thermal_current;
    next_s.therm_en = (next_s.therm_cur != THERMAL_OFF);
    if (sec && second_cfg.second_torque_boost != BOOST_UNUSED)
      next_s.boost = second_cfg.second_torque_boost;
    else
      next_s.boost = second_cfg.torque_boost;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s            <= '0;
      s.phase      <= SSR_IDLE;
      s.brake_volt <= BRAKE_VOLT_DEFAULT;
    end
    else
      s <= next_s;
  end

  assign out_freq              = s.freq;
  assign active_code           = s.code;
  assign brake_active          = s.brake_on;
  assign brake_level           = s.level;
  assign brake_voltage_setting = s.brake_volt;
  assign second_active         = s.second;
  assign thermal_enable        = s.therm_en;
  assign thermal_current       = s.therm_cur;
  assign torque_boost_out      = s.boost;
endmodule // ssr_top
`default_nettype wire

// ==== dv/ssr_contact_model.sv ====
/*
  ssr_contact_model: switch panel in front of the contact pins.
  Assumes the bench asks for levels; contacts move only at falling edges.
*/
`timescale 1ns/1ns
`default_nettype none
module ssr_contact_model
  import ssr_pkg::*;
(
  // clock
  input  wire logic      clk,
  // requested levels
  input  wire ssr_speed_t want_speed,
  input  wire logic      want_second,
  input  wire logic      want_run,
  // contacts
  output ssr_speed_t     speed_pins,
  output logic           second_pin,
  output logic           run_out
);
  // no bounce modelled; the design's synchronisers see clean levels
  initial
  begin
    speed_pins = '0;
    second_pin = 1'b0;
    run_out    = 1'b0;
  end
  always @(negedge clk)
  begin
    speed_pins <= want_speed;
    second_pin <= want_second;
    run_out    <= want_run;
  end
endmodule // ssr_contact_model
`default_nettype wire

// ==== dv/ssr_top_properties.sv ====
/*
  ssr_top_properties: concurrent checks on the ports of ssr_top.
  Assumes one clock, sync active-high reset, bound to every ssr_top.
*/
`timescale 1ns/1ns
`default_nettype none
module ssr_top_properties
  import ssr_pkg::*;
#(
  parameter logic [31:0] BRAKE_CYC = BRAKE_UNIT_CYC
)
(
  // clock and reset
  input wire logic            clk,
  input wire logic            rst,
  // watched inputs
  input wire ssr_mode_t       op_mode,
  input wire ssr_speed_t      net_speed,
  input wire logic            net_second,
  input wire ssr_preset_tab_t presets,
  input wire ssr_second_cfg_t second_cfg,
  input wire ssr_brake_cfg_t  brake_cfg,
  input wire logic [7:0]      brake_voltage_pct,
  input wire logic            brake_voltage_wr,
  input wire logic [7:0]      applied_motor_sel,
  // watched outputs
  input wire logic [15:0]     out_freq,
  input wire logic [3:0]      active_code,
  input wire logic            brake_active,
  input wire logic [7:0]      brake_level,
  input wire logic [7:0]      brake_voltage_setting,
  input wire logic            thermal_enable,
  input wire logic [15:0]     thermal_current
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // cycles spent braking, cleared when idle
  logic [31:0] brake_cnt;
  always_ff @(posedge clk)
  begin
    if (rst || !brake_active)
      brake_cnt <= '0;
    else
      brake_cnt <= brake_cnt + 32'h1;
  end
  a_code_high: assert property (op_mode == SSR_MODE_NETWORK && net_speed == 4'h4
    |=> active_code == CODE_HIGH) else $error("high input not selected");
  a_three_lower: assert property (op_mode == SSR_MODE_NETWORK && net_speed == 4'h3
    && presets[4] == SETTING_UNUSED |=> active_code == CODE_LOW)
    else $error("lower input not preferred");
  a_freq_limit: assert property (out_freq <= FREQ_LIMIT)
    else $error("output above limit");
  a_step_one: assert property (!$rose(brake_active) |-> out_freq == $past(out_freq)
    || out_freq == $past(out_freq) + 16'h1 || out_freq + 16'h1 == $past(out_freq))
    else $error("ramp step larger than one count");
  a_thermal_off: assert property (thermal_enable == (thermal_current != THERMAL_OFF))
    else $error("thermal enable disagrees with current");
  a_thermal_first: assert property (op_mode == SSR_MODE_NETWORK && !net_second
    |=> thermal_enable == ($past(second_cfg.motor_thermal_current) != THERMAL_OFF))
    else $error("thermal enable ignores first current");
  a_second_thermal: assert property (op_mode == SSR_MODE_NETWORK && net_second
    && second_cfg.second_motor_thermal_current != SETTING_UNUSED
    |=> thermal_current == $past(second_cfg.second_motor_thermal_current))
    else $error("second thermal current not used");
  a_volt_write: assert property (brake_voltage_wr |=> brake_voltage_setting
    == ($past(brake_voltage_pct) > BRAKE_VOLT_MAX ? BRAKE_VOLT_MAX : $past(brake_voltage_pct)))
    else $error("brake voltage write wrong");
  a_volt_ct: assert property (!brake_voltage_wr && applied_motor_sel == MOTOR_CT
    && $past(applied_motor_sel) != MOTOR_CT && brake_voltage_setting == BRAKE_VOLT_DEFAULT
    |=> brake_voltage_setting == BRAKE_VOLT_CT) else $error("constant-torque voltage not set");
  a_brake_level: assert property (brake_level == (brake_active ? brake_voltage_setting
    : LEVEL_OFF)) else $error("brake level wrong");
  a_brake_entry: assert property ($rose(brake_active) |-> out_freq == FREQ_ZERO
    && $past(out_freq) <= brake_cfg.brake_start_freq) else $error("brake started wrongly");
  a_brake_span: assert property ($fell(brake_active) |-> brake_cnt
    == 32'(brake_cfg.brake_duration) * BRAKE_CYC) else $error("brake time wrong");
  c_brake: cover property ($fell(brake_active));
  c_code_top: cover property (active_code == 4'hF);
  c_second: cover property (op_mode == SSR_MODE_NETWORK && net_second);
endmodule // ssr_top_properties
bind ssr_top ssr_top_properties #(.BRAKE_CYC(BRAKE_CYC)) u_props (.clk, .rst, .op_mode,
  .net_speed, .net_second, .presets, .second_cfg, .brake_cfg, .brake_voltage_pct,
  .brake_voltage_wr, .applied_motor_sel, .out_freq, .active_code, .brake_active,
  .brake_level, .brake_voltage_setting, .thermal_enable, .thermal_current);
`default_nettype wire

// ==== dv/ssr_top_tb.sv ====
/*
  ssr_top_tb: self-checking bench for ssr_top with shortened time units.
  Assumes ssr_top_properties is bound in; inputs change at falling edges.
*/
`timescale 1ns/1ns
`default_nettype none
module ssr_top_tb;
  import ssr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  ssr_speed_t want_speed = '0, speed_pins, net_speed = '0;
  logic sfs, run_pin, net_second = 1'b0, net_run = 1'b0, wr = 1'b0;
  logic want_sec = 1'b0, want_run = 1'b0;
  ssr_mode_t op_mode = SSR_MODE_NETWORK;
  ssr_preset_tab_t presets;
  logic [15:0] freq_command = 16'h0014, max_freq = 16'h9C40, out_freq, thermal_current;
  logic [15:0] min_freq = 16'h0000;
  ssr_ramp_cfg_t ramp_cfg = '{16'h0001, 16'h0002, 16'h0000, 16'hFFFF, 16'h0014, 16'h0014, 1'b0, 1'b0};
  ssr_second_cfg_t second_cfg = '{16'h0100, 16'h0123, 8'h06, 8'h09};
  ssr_brake_cfg_t brake_cfg = '{16'h0005, 8'h01};
  logic [7:0] pct = 8'h06, motor_sel = 8'h00, brake_level, volt_set, boost;
  logic [3:0] active_code;
  logic brake_active, second_active, thermal_enable;
  int err_total = 0, checks_done = 0, n;
  // {extra,high,middle,low} code beside the selected index
  logic [7:0] rows [16] = '{8'h00, 8'h13, 8'h22, 8'h34, 8'h41, 8'h55, 8'h66, 8'h77,
                            8'h88, 8'h99, 8'hAA, 8'hBB, 8'hCC, 8'hDD, 8'hEE, 8'hFF};
  always #2 clk = ~clk;
  initial for (int i = 1; i < 16; i++) presets[i] = 16'(i);
  ssr_contact_model u_panel (.clk(clk), .want_speed(want_speed), .want_second(want_sec),
    .want_run(want_run), .speed_pins(speed_pins), .second_pin(sfs), .run_out(run_pin));
  ssr_top #(.COARSE_CYC(32'd100), .FINE_CYC(32'd10), .ZERO_CYC(32'd40), .BRAKE_CYC(32'd100)) dut
    (.clk(clk), .rst(rst), .speed_pins(speed_pins), .second_function_select(sfs),
    .run_pin(run_pin), .op_mode(op_mode), .net_speed(net_speed), .net_second(net_second),
    .net_run(net_run), .presets(presets), .freq_command(freq_command), .max_freq(max_freq),
    .min_freq(min_freq), .ramp_cfg(ramp_cfg), .second_cfg(second_cfg), .brake_cfg(brake_cfg),
    .brake_voltage_pct(pct), .brake_voltage_wr(wr), .applied_motor_sel(motor_sel),
    .out_freq(out_freq), .active_code(active_code), .brake_active(brake_active),
    .brake_level(brake_level), .brake_voltage_setting(volt_set), .second_active(second_active),
    .thermal_enable(thermal_enable), .thermal_current(thermal_current), .torque_boost_out(boost));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // cycles until out_freq reaches tgt must lie in [lo, hi]
  task automatic ramp(input string name, input logic [15:0] tgt, input int lo, input int hi);
    n = 0;
    while (out_freq !== tgt && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    check(name, 16'(n >= lo && n <= hi), 16'h1);
    $display("test %s done after %0d cycles", name, n);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #40000;
    err_total++;
    stop_test;
  end
  initial
  begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    check("reset out_freq", out_freq, 16'h0);
    check("reset voltage", {8'h0, volt_set}, 16'h0006);
    for (int i = 0; i < 16; i++)
    begin
      net_speed = rows[i][7:4];
      @(negedge clk);
      check("active_code", {12'h0, active_code}, {12'h0, rows[i][3:0]});
    end
    $display("test code table done");
    op_mode = SSR_MODE_PANEL;
    want_speed = 4'hF;
    want_sec = 1'b1;
    repeat (5) @(negedge clk);
    check("panel code", {12'h0, active_code}, 16'h000F);
    check("pin second", {15'h0, second_active}, 16'h0001);
    op_mode = SSR_MODE_EXTERNAL;
    want_speed = 4'h2;
    want_sec = 1'b0;
    repeat (5) @(negedge clk);
    check("external code", {12'h0, active_code}, 16'h0002);
    check("pin second off", {15'h0, second_active}, 16'h0000);
    op_mode = SSR_MODE_NETWORK;
    presets[4] = SETTING_UNUSED;
    net_speed = 4'h3;
    @(negedge clk);
    check("three speed", {12'h0, active_code}, 16'h0003);
    presets[1] = SETTING_UNUSED;
    net_speed = 4'h4;
    net_run = 1'b1;
    ramp("accel command", 16'h0014, 95, 110);
    presets[1] = 16'h000A;
    ramp("decel running", 16'h000A, 95, 115);
    net_second = 1'b1;
    presets[1] = 16'h0014;
    ramp("second accel", 16'h0014, 18, 26);
    check("second thermal", thermal_current, 16'h0123);
    check("second boost", {8'h0, boost}, 16'h0009);
    presets[1] = 16'h000A;
    ramp("second decel", 16'h000A, 18, 26);
    net_second = 1'b0;
    ramp_cfg.ramp_time_increment_sel = 1'b1;
    ramp_cfg.accel_time = 16'h0004;
    presets[1] = 16'h0014;
    ramp("fine accel", 16'h0014, 18, 26);
    ramp_cfg.scurve_a = 1'b1;
    ramp_cfg.base_freq = 16'h000A;
    presets[1] = 16'h001E;
    ramp("s-curve accel", 16'h001E, 55, 66);
    ramp_cfg.scurve_a = 1'b0;
    ramp_cfg.ramp_time_increment_sel = 1'b0;
    max_freq = 16'h000F;
    ramp("max clamp", 16'h000F, 140, 160);
    net_run = 1'b0;
    n = 0;
    while (brake_active !== 1'b1 && n < 500)
    begin
      @(negedge clk);
      n++;
    end
    check("brake out", out_freq, 16'h0);
    check("brake level", {8'h0, brake_level}, 16'h0006);
    n = 0;
    while (brake_active === 1'b1 && n < 1000)
    begin
      @(negedge clk);
      n++;
    end
    check("brake span", 16'(n), 16'd100);
    $display("test brake done");
    pct = 8'h28;
    wr = 1'b1;
    @(negedge clk);
    check("volt clamp", {8'h0, volt_set}, 16'h001E);
    pct = 8'h06;
    @(negedge clk);
    wr = 1'b0;
    motor_sel = MOTOR_CT;
    repeat (2) @(negedge clk);
    check("volt ct", {8'h0, volt_set}, 16'h0004);
    second_cfg.motor_thermal_current = 16'h0000;
    @(negedge clk);
    check("thermal off", {15'h0, thermal_enable}, 16'h0);
    $display("test settings done");
    op_mode = SSR_MODE_EXTERNAL;
    want_speed = 4'h4;
    want_run = 1'b1;
    ramp("pin run", 16'h0001, 20, 30);
    stop_test;
  end
endmodule // ssr_top_tb
`default_nettype wire
